/* common/fpm_consts.svh */
// Timing counts, display codes and reset values for the front-panel menu
`ifndef FPM_CONSTS_SVH
`define FPM_CONSTS_SVH
`define FPM_CLK_HZ        50000000
`define FPM_DEBOUNCE_MS   20
`define FPM_DEBOUNCE_CYC  ((`FPM_CLK_HZ / 1000) * `FPM_DEBOUNCE_MS)
`define FPM_HALF_S_MS     500
`define FPM_ONE_S_MS      1000
`define FPM_TEN_S_MS      10000
`define FPM_TEST_S        15
`define FPM_IDLE_S        300
`define FPM_BLANK_MS      1000
`define FPM_REPEAT_MS     1000
`define FPM_FLASH_MS      250
`define FPM_CONFIRM_MS    1000
`define FPM_ADDR_RESET    10'h146
`define FPM_RATE_RESET    10'h096
`define FPM_NUM_KNOBS     5
`define FPM_NUM_ITEMS     8
`define FPM_REG_A_POS     4'h7
`define FPM_DIGIT_BLANK   4'hf
`define FPM_DIGIT_DASH    4'he
`define FPM_DIGIT_A       4'ha
`endif

/* common/fpm_pkg.sv */
// Types shared by the front-panel menu controller
package fpm_pkg;
    typedef enum logic [2:0] {
        FPM_TEST    = 3'b000,
        FPM_BLANK   = 3'b001,
        FPM_MAIN    = 3'b011,
        FPM_SUB     = 3'b010,
        FPM_SET     = 3'b110,
        FPM_CONFIRM = 3'b111
    } fpm_state_e;
    typedef enum logic [1:0] {
        FPM_PR_NONE  = 2'h0,
        FPM_PR_SHORT = 2'h1,
        FPM_PR_ONE   = 2'h2,
        FPM_PR_LONG  = 2'h3
    } fpm_press_e;
endpackage

/* core/fpm_menu.sv */
// Front-panel push-button menu, display and setting-mode controller
// How it works
// - Step button advances display; reset button clears red operation indicators.
// - Knob change while other value shown jumps display there, lights its LED.
// - Remote knob/switch change taken only with password and remote flag zero.
// - Remote settings active: displayed knob indicator flashes instead of glowing.
// - Four digits: three right show value, leftmost shows register number.
// - Outside test and submenu, register digit lit only while a stored value is displayed.
// - After power-up cycle digits about 15 s, then blank display.
// - A step press aborts the power-up display test.
// - Display test never blocks protection logic.
// - From blank only forward; held step keeps advancing, pausing at blank.
// - Main menu: one-second step goes forward, half-second goes back.
// - Display goes off five minutes after last step unless stepped to blank.
// - One-second reset enters submenu; on release register digit flashes.
// - Submenu steps like main menu; dark red digit means main menu.
// - Submenu keeps knob LED lit and flashes register digit.
// - Ten-second reset enters setting mode, rightmost digit flashing.
// - In setting mode each step press changes the flashing digit.
// - In setting mode each reset press moves edit right, middle, left.
// - Both buttons commit the value; operator holds reset slightly longer.
// - Ten-second reset in setting mode returns to the originating menu.
// - Idle setting mode returns to start condition after five minutes.
// - Address code starts at 146.
// - On commit three green dashes flash.
// - Address in register A, data rate in its submenu 1.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fpm_consts.svh"
module fpm_menu
    import fpm_pkg::*;
#(
    parameter int TEST_CYC  = `FPM_TEST_S * `FPM_CLK_HZ,
    parameter longint IDLE_CYC = 64'(`FPM_IDLE_S) * `FPM_CLK_HZ,
    parameter int HALF_CYC  = (`FPM_CLK_HZ / 1000) * `FPM_HALF_S_MS,
    parameter int ONE_CYC   = (`FPM_CLK_HZ / 1000) * `FPM_ONE_S_MS,
    parameter int TEN_CYC   = (`FPM_CLK_HZ / 1000) * `FPM_TEN_S_MS,
    parameter int DEB_CYC   = `FPM_DEBOUNCE_CYC,
    parameter int FLASH_CYC = (`FPM_CLK_HZ / 1000) * `FPM_FLASH_MS,
    parameter int NKNOB     = `FPM_NUM_KNOBS
) (
    // Clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst,
    // Front-panel buttons, raw pins
    input  wire logic              i_step_btn,
    input  wire logic              i_reset_btn,
    // Knob movement strobes from the knob scanner
    input  wire logic [NKNOB-1:0]  i_knob_changed,
    input  wire logic [11:0]       i_knob_value,
    // Remote setting request
    input  wire logic              i_remote_wr,
    input  wire logic              i_password_ok,
    input  wire logic              i_remote_settings_active_param,
    // Measured / stored value of the selected display item
    input  wire logic [11:0]       i_item_value,
    // Display
    output logic [3:0]             o_digit_reg,
    output logic [3:0]             o_digit2,
    output logic [3:0]             o_digit1,
    output logic [3:0]             o_digit0,
    output logic                   o_reg_digit_on,
    output logic [2:0]             o_green_blink,
    output logic [NKNOB-1:0]       o_knob_led,
    output logic [3:0]             o_item_sel,
    output logic [3:0]             o_submenu,
    // Effects on the rest of the relay
    output logic                   o_clear_red_ind,
    output logic                   o_remote_accept,
    output logic [9:0]             o_address_code,
    output logic [9:0]             o_data_rate,
    output logic                   o_store_pulse
);
    // Wide enough for the five-minute idle count at the full clock rate
    localparam int CW = 34;

    // Thresholds must rise strictly or the press classes overlap
    if (NKNOB < 1 || NKNOB > `FPM_NUM_ITEMS || HALF_CYC >= ONE_CYC
        || ONE_CYC >= TEN_CYC || DEB_CYC < 1) begin : g_bad_param
        $error("fpm_menu: bad parameters");
    end

    // Two-flop synchronisers on the raw pins
    logic [1:0] step_sync_ff;
    logic [1:0] rst_sync_ff;
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            step_sync_ff <= 2'h0;
            rst_sync_ff  <= 2'h0;
        end else begin
            step_sync_ff <= {step_sync_ff[0], i_step_btn};
            rst_sync_ff  <= {rst_sync_ff[0], i_reset_btn};
        end
    end

    // Debounce and hold timers for both buttons
    logic [1:0]    raw;
    logic [1:0]    deb_ff;
    logic [1:0]    deb_prev_ff;
    logic [CW-1:0] deb_cnt_ff [2];
    logic [CW-1:0] hold_ff [2];
    assign raw = {rst_sync_ff[1], step_sync_ff[1]};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_btn
            always_ff @(posedge i_ref_clk) begin
                if (i_rst) begin
                    deb_ff[g]     <= 1'b0;
                    deb_cnt_ff[g] <= '0;
                end else if (raw[g] == deb_ff[g]) begin
                    deb_cnt_ff[g] <= '0;
                end else if (deb_cnt_ff[g] >= CW'(DEB_CYC - 1)) begin
                    deb_ff[g]     <= raw[g];
                    deb_cnt_ff[g] <= '0;
                end else begin
                    deb_cnt_ff[g] <= deb_cnt_ff[g] + 1'b1;
                end
            end
            always_ff @(posedge i_ref_clk) begin
                if (i_rst) begin
                    hold_ff[g]     <= '0;
                    deb_prev_ff[g] <= 1'b0;
                end else begin
                    deb_prev_ff[g] <= deb_ff[g];
                    if (!deb_ff[g]) begin
                        hold_ff[g] <= '0;
                    end else if (hold_ff[g] != '1) begin
                        hold_ff[g] <= hold_ff[g] + 1'b1;
                    end
                end
            end
        end
    endgenerate

    function automatic fpm_press_e classify(input logic [CW-1:0] t);
        if (t >= CW'(TEN_CYC)) begin
            return FPM_PR_LONG;
        end else if (t >= CW'(ONE_CYC)) begin
            return FPM_PR_ONE;
        end else if (t >= CW'(HALF_CYC)) begin
            return FPM_PR_SHORT;
        end
        return FPM_PR_NONE;
    endfunction

    logic       step_press;
    logic       step_rel;
    logic       rst_rel;
    logic       rst_ten_hit;
    logic       step_one_hit;
    fpm_press_e step_cls;
    fpm_press_e rst_cls;
    logic       both_ff;
    assign step_press   = deb_ff[0] && !deb_prev_ff[0];
    assign step_rel     = !deb_ff[0] && deb_prev_ff[0];
    assign rst_rel      = !deb_ff[1] && deb_prev_ff[1];
    assign rst_ten_hit  = deb_ff[1] && (hold_ff[1] == CW'(TEN_CYC));
    assign step_one_hit = deb_ff[0] && (hold_ff[0] == CW'(ONE_CYC));
    assign step_cls     = classify(hold_ff[0]);
    assign rst_cls      = classify(hold_ff[1]);

    // Remember that both were down, so the later reset release is the commit
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            both_ff <= 1'b0;
        end else if (deb_ff[0] && deb_ff[1]) begin
            both_ff <= 1'b1;
        end else if (!deb_ff[1]) begin
            both_ff <= 1'b0;
        end
    end

    // Menu state machine
    fpm_state_e    state_ff;
    fpm_state_e    ret_state_ff;
    logic [3:0]    item_ff;
    logic [3:0]    sub_ff;
    logic [1:0]    edit_pos_ff;
    logic [CW-1:0] timer_ff;
    logic [CW-1:0] idle_ff;
    logic          ten_done_ff;
    logic [11:0]   edit_ff;
    logic          knob_ev;
    logic [3:0]    knob_idx;
    assign knob_ev = |i_knob_changed;
    always_comb begin
        knob_idx = 4'h0;
        for (int k = NKNOB - 1; k >= 0; k--) begin
            if (i_knob_changed[k]) begin
                knob_idx = 4'(k);
            end
        end
    end

    function automatic logic [3:0] inc_digit(input logic [3:0] d);
        return (d >= 4'h9) ? 4'h0 : d + 4'h1;
    endfunction

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_ff     <= FPM_TEST;
            ret_state_ff <= FPM_MAIN;
            item_ff      <= 4'h0;
            sub_ff       <= 4'h0;
            edit_pos_ff  <= 2'h0;
            timer_ff     <= '0;
            idle_ff      <= '0;
            ten_done_ff  <= 1'b0;
            edit_ff      <= 12'h000;
        end else begin
            timer_ff <= timer_ff + 1'b1;
            idle_ff  <= (step_press || (state_ff == FPM_SET &&
                        (deb_ff[0] || deb_ff[1]))) ? '0 : idle_ff + 1'b1;
            if (!deb_ff[1]) begin
                ten_done_ff <= 1'b0;
            end
            unique case (state_ff)
                FPM_TEST: begin
                    // Only the display is tied up; protection runs aside
                    if (step_press) begin
                        state_ff <= FPM_BLANK;
                    end else if (timer_ff >= CW'(TEST_CYC - 1)) begin
                        state_ff <= FPM_BLANK;
                    end
                end
                FPM_BLANK: begin
                    if (knob_ev) begin
                        state_ff <= FPM_MAIN;
                        item_ff  <= knob_idx;
                        idle_ff  <= '0;
                    end else if (step_rel || step_one_hit) begin
                        state_ff <= FPM_MAIN;
                        item_ff  <= 4'h0;
                        timer_ff <= '0;
                    end
                end
                FPM_MAIN, FPM_SUB: begin
                    if (knob_ev) begin
                        state_ff <= FPM_MAIN;
                        item_ff  <= knob_idx;
                        sub_ff   <= 4'h0;
                    end else if (idle_ff >= CW'(IDLE_CYC - 1)) begin
                        state_ff <= FPM_BLANK;
                        sub_ff   <= 4'h0;
                    end else if (rst_ten_hit && !deb_ff[0]) begin
                        state_ff     <= FPM_SET;
                        ret_state_ff <= state_ff;
                        edit_pos_ff  <= 2'h0;
                        ten_done_ff  <= 1'b1;
                        edit_ff      <= (item_ff == `FPM_REG_A_POS) ?
                            ((sub_ff == 4'h1) ? {2'h0, o_data_rate} :
                             {2'h0, o_address_code}) : i_item_value;
                    end else if (rst_rel && !both_ff && !ten_done_ff
                                 && rst_cls == FPM_PR_ONE) begin
                        state_ff <= FPM_SUB;
                        sub_ff   <= sub_ff + 4'h1;
                    end else if (step_one_hit && state_ff == FPM_MAIN
                                 && item_ff == 4'(`FPM_NUM_ITEMS - 1)) begin
                        state_ff <= FPM_BLANK;
                    end else if (step_one_hit) begin
                        timer_ff <= '0; // Repeat only a full hold later
                        if (state_ff == FPM_SUB) begin
                            sub_ff <= sub_ff + 4'h1;
                        end else begin
                            item_ff <= item_ff + 4'h1;
                        end
                    end else if (deb_ff[0] && hold_ff[0] >
                                 CW'(ONE_CYC) && timer_ff >= CW'(ONE_CYC)) begin
                        timer_ff <= '0; // Held step keeps stepping
                        if (state_ff == FPM_MAIN) begin
                            if (item_ff == 4'(`FPM_NUM_ITEMS - 1)) begin
                                state_ff <= FPM_BLANK;
                            end else begin
                                item_ff <= item_ff + 4'h1;
                            end
                        end else begin
                            sub_ff <= sub_ff + 4'h1;
                        end
                    end else if (step_rel && step_cls == FPM_PR_SHORT
                                 && hold_ff[0] < CW'(ONE_CYC)) begin
                        if (state_ff == FPM_SUB) begin
                            if (sub_ff == 4'h1) begin
                                state_ff <= FPM_MAIN;
                            end
                            sub_ff <= sub_ff - 4'h1;
                        end else if (item_ff != 4'h0) begin
                            item_ff <= item_ff - 4'h1;
                        end
                    end
                end
                FPM_SET: begin
                    if (idle_ff >= CW'(IDLE_CYC - 1)) begin
                        state_ff <= FPM_BLANK;
                        sub_ff   <= 4'h0;
                    end else if (rst_ten_hit) begin
                        state_ff    <= ret_state_ff;
                        ten_done_ff <= 1'b1;
                    end else if (rst_rel && both_ff) begin
                        state_ff <= FPM_CONFIRM;
                        timer_ff <= '0;
                    end else if (step_press && !deb_ff[1]) begin
                        unique case (edit_pos_ff)
                            2'h0: edit_ff[3:0]  <= inc_digit(edit_ff[3:0]);
                            2'h1: edit_ff[7:4]  <= inc_digit(edit_ff[7:4]);
                            default: edit_ff[11:8] <= inc_digit(edit_ff[11:8]);
                        endcase
                    end else if (rst_rel && !ten_done_ff) begin
                        edit_pos_ff <= (edit_pos_ff == 2'h2) ? 2'h0 :
                                       edit_pos_ff + 2'h1;
                    end
                end
                FPM_CONFIRM: begin
                    if (timer_ff >= CW'(ONE_CYC)) begin
                        state_ff <= FPM_SET;
                    end
                end
                default: state_ff <= FPM_BLANK;
            endcase
        end
    end

    // Parameter store; BCD digits, address code and rate in register A
    logic store_hit;
    assign store_hit = state_ff == FPM_SET && rst_rel && both_ff
                       && idle_ff < CW'(IDLE_CYC - 1) && !rst_ten_hit;
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_address_code <= `FPM_ADDR_RESET;
            o_data_rate    <= `FPM_RATE_RESET;
            o_store_pulse  <= 1'b0;
        end else begin
            o_store_pulse <= store_hit;
            if (store_hit && item_ff == `FPM_REG_A_POS) begin
                if (sub_ff == 4'h1) begin
                    o_data_rate <= edit_ff[9:0];
                end else if (sub_ff == 4'h0) begin
                    o_address_code <= edit_ff[9:0];
                end
            end
        end
    end

    // Flash phase divider
    logic [CW-1:0] flash_cnt_ff;
    logic          flash_ff;
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            flash_cnt_ff <= '0;
            flash_ff     <= 1'b0;
        end else if (flash_cnt_ff >= CW'(FLASH_CYC - 1)) begin
            flash_cnt_ff <= '0;
            flash_ff     <= !flash_ff;
        end else begin
            flash_cnt_ff <= flash_cnt_ff + 1'b1;
        end
    end

    // Button side effects and remote-write acceptance
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_clear_red_ind <= 1'b0;
            o_remote_accept <= 1'b0;
        end else begin
            o_clear_red_ind <= rst_rel && !both_ff && state_ff != FPM_SET
                               && rst_cls == FPM_PR_NONE;
            o_remote_accept <= i_remote_wr && i_password_ok
                               && !i_remote_settings_active_param;
        end
    end

    // Display drive, all registered
    logic        is_knob;
    logic        is_stored;
    logic [11:0] show;
    assign is_knob   = item_ff < 4'(NKNOB);
    assign is_stored = !is_knob;
    assign show      = (state_ff == FPM_SET) ? edit_ff :
                       (item_ff == `FPM_REG_A_POS && state_ff == FPM_MAIN) ?
                       {2'h0, o_address_code} : i_item_value;
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_digit_reg    <= `FPM_DIGIT_BLANK;
            o_digit2       <= `FPM_DIGIT_BLANK;
            o_digit1       <= `FPM_DIGIT_BLANK;
            o_digit0       <= `FPM_DIGIT_BLANK;
            o_reg_digit_on <= 1'b0;
            o_green_blink  <= 3'h0;
            o_knob_led     <= '0;
            o_item_sel     <= 4'h0;
            o_submenu      <= 4'h0;
        end else begin
            o_item_sel    <= item_ff;
            o_submenu     <= sub_ff;
            o_green_blink <= 3'h0;
            o_knob_led    <= '0;
            unique case (state_ff)
                FPM_TEST: begin
                    o_digit_reg    <= timer_ff[27:24];
                    o_digit2       <= timer_ff[27:24];
                    o_digit1       <= timer_ff[27:24];
                    o_digit0       <= timer_ff[27:24];
                    o_reg_digit_on <= 1'b1;
                end
                FPM_BLANK: begin
                    o_digit_reg    <= `FPM_DIGIT_BLANK;
                    o_digit2       <= `FPM_DIGIT_BLANK;
                    o_digit1       <= `FPM_DIGIT_BLANK;
                    o_digit0       <= `FPM_DIGIT_BLANK;
                    o_reg_digit_on <= 1'b0;
                end
                FPM_CONFIRM: begin
                    // Steady dashes; the blink mask makes them flash
                    o_digit2 <= `FPM_DIGIT_DASH;
                    o_digit1 <= `FPM_DIGIT_DASH;
                    o_digit0 <= `FPM_DIGIT_DASH;
                    o_green_blink <= 3'h7;
                end
                default: begin
                    o_digit2 <= show[11:8];
                    o_digit1 <= show[7:4];
                    o_digit0 <= show[3:0];
                    o_digit_reg <= (sub_ff != 4'h0) ? sub_ff :
                        (item_ff == `FPM_REG_A_POS) ? `FPM_DIGIT_A :
                        item_ff - 4'(NKNOB);
                    if (state_ff == FPM_SUB) begin
                        o_reg_digit_on <= flash_ff;
                    end else begin
                        o_reg_digit_on <= is_stored;
                    end
                    if (state_ff == FPM_SET) begin
                        o_green_blink <= 3'(1 << edit_pos_ff);
                    end
                    if (is_knob) begin
                        o_knob_led[item_ff[2:0]] <=
                            i_remote_settings_active_param ? flash_ff
                            : 1'b1;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* tb/fpm_menu_properties.sv */
// Port-level assertions for the front-panel menu controller
`timescale 1ns/1ps
`default_nettype none
module fpm_menu_chk
    import fpm_pkg::*;
#(
    parameter int NKNOB = 5
) (
    // Clock and reset
    input wire logic             i_ref_clk,
    input wire logic             i_rst,
    // Inputs watched
    input wire logic [NKNOB-1:0] i_knob_changed,
    input wire logic             i_remote_wr,
    input wire logic             i_password_ok,
    input wire logic             i_remote_settings_active_param,
    // Outputs watched
    input wire logic [3:0]       o_digit2,
    input wire logic [3:0]       o_digit1,
    input wire logic [3:0]       o_digit0,
    input wire logic [2:0]       o_green_blink,
    input wire logic [3:0]       o_item_sel,
    input wire logic             o_clear_red_ind,
    input wire logic             o_remote_accept,
    input wire logic             o_store_pulse
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence s_remote_ok;
        i_remote_wr && i_password_ok && !i_remote_settings_active_param;
    endsequence
    sequence s_remote_bad;
        i_remote_wr && (!i_password_ok || i_remote_settings_active_param);
    endsequence
    a_remote_take: assert property (s_remote_ok |=> o_remote_accept)
        else $error("remote write not accepted");
    a_remote_refuse: assert property (s_remote_bad |=> !o_remote_accept)
        else $error("remote write accepted wrongly");
    a_accept_cause: assert property (o_remote_accept |->
        $past(i_remote_wr) && !$past(i_remote_settings_active_param))
        else $error("accept without request");
    a_store_once: assert property (o_store_pulse |=> !o_store_pulse)
        else $error("store pulse too long");
    a_clear_once: assert property (o_clear_red_ind |=> !o_clear_red_ind)
        else $error("clear pulse too long");
    a_dash_show: assert property (o_green_blink == 3'h7 |->
        {o_digit2, o_digit1, o_digit0} == 12'heee)
        else $error("commit without dashes");
    a_edit_single: assert property (o_green_blink != 3'h7 |->
        $onehot0(o_green_blink))
        else $error("more than one edit digit");
    a_knob_jump: assert property (i_knob_changed[2] &&
        i_knob_changed[1:0] == 2'h0 |-> ##[1:3] o_item_sel == 4'h2)
        else $error("knob move did not switch display");
endmodule
bind fpm_menu fpm_menu_chk #(.NKNOB(NKNOB)) chk_u (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_knob_changed(i_knob_changed),
    .i_remote_wr(i_remote_wr), .i_password_ok(i_password_ok),
    .i_remote_settings_active_param(i_remote_settings_active_param),
    .o_digit2(o_digit2), .o_digit1(o_digit1), .o_digit0(o_digit0),
    .o_green_blink(o_green_blink), .o_item_sel(o_item_sel),
    .o_clear_red_ind(o_clear_red_ind), .o_remote_accept(o_remote_accept),
    .o_store_pulse(o_store_pulse));
`default_nettype wire

/* tb/fpm_operator.sv */
// Behavioural operator pressing the two front-panel buttons
`timescale 1ns/1ps
`default_nettype none
module fpm_operator (
    // Clock
    input  wire logic i_ref_clk,
    // Button pins
    output var logic  o_step_btn,
    output var logic  o_reset_btn
);
    initial begin
        o_step_btn = 1'b0;
        o_reset_btn = 1'b0;
    end
    // Ends on a falling edge so callers sample settled outputs
    task automatic press(input logic s, input logic r, input int n);
        @(posedge i_ref_clk);
        o_step_btn <= s;
        o_reset_btn <= r;
        repeat (n) @(posedge i_ref_clk);
        o_step_btn <= 1'b0;
        if (s && r) repeat (8) @(posedge i_ref_clk);
        o_reset_btn <= 1'b0;
        repeat (30) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
    endtask
endmodule
`default_nettype wire

/* tb/fpm_menu_bench.sv */
// Self-checking bench for the front-panel menu controller
`timescale 1ns/1ps
`default_nettype none
module fpm_menu_bench;
    import fpm_pkg::*;
    localparam int ONE = 40;
    localparam int TEN = 200;
    localparam int TST = 200, IDL = 5000, HLF = 20, DEB = 2, FLS = 5;
    logic [11:0] kval, ival;
    logic       clk, i_rst, wr, pw, prm, regon, clr, acc, store;
    logic [4:0] knob, led;
    logic [3:0] dreg, d2, d1, d0, item, sub;
    logic [2:0] gb;
    logic [9:0] addr, rate;
    wire logic  stp, rbt;
    int n_mismatch = 0, samples_checked = 0, n_clr = 0, n_store = 0;
    fpm_operator op_u (.i_ref_clk(clk), .o_step_btn(stp), .o_reset_btn(rbt));
    fpm_menu #(.TEST_CYC(TST), .IDLE_CYC(IDL), .HALF_CYC(HLF), .ONE_CYC(ONE),
        .TEN_CYC(TEN), .DEB_CYC(DEB), .FLASH_CYC(FLS)) dut_u (
        .i_ref_clk(clk), .i_rst(i_rst), .i_step_btn(stp), .i_reset_btn(rbt),
        .i_knob_changed(knob), .i_knob_value(kval), .i_remote_wr(wr),
        .i_password_ok(pw), .i_remote_settings_active_param(prm),
        .i_item_value(ival), .o_digit_reg(dreg), .o_digit2(d2),
        .o_digit1(d1), .o_digit0(d0), .o_reg_digit_on(regon),
        .o_green_blink(gb), .o_knob_led(led), .o_item_sel(item),
        .o_submenu(sub), .o_clear_red_ind(clr), .o_remote_accept(acc),
        .o_address_code(addr), .o_data_rate(rate), .o_store_pulse(store));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (clr === 1'b1) n_clr++;
        if (store === 1'b1) n_store++;
    end
    task automatic chk(input string nm, input logic [11:0] e,
                       input logic [11:0] g);
        samples_checked++;
        if (e !== g) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic t_power;
        repeat (230) @(posedge clk);
        @(negedge clk);
        chk("digit0", 12'hf, 12'(d0));
        chk("reg_on", 12'h0, 12'(regon));
        chk("address", 12'h146, 12'(addr));
        chk("rate", 12'h096, 12'(rate));
    endtask
    task automatic t_remote;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            wr <= 1'b1;
            pw <= (k != 1);
            prm <= (k == 2);
            @(posedge clk);
            wr <= 1'b0;
            @(negedge clk);
            chk("accept", 12'(k == 0), 12'(acc));
        end
        @(posedge clk);
        prm <= 1'b0;
    endtask
    task automatic t_nav;
        op_u.press(1'b1, 1'b0, ONE + 12);
        chk("item", 12'h0, 12'(item));
        op_u.press(1'b0, 1'b1, 10);
        chk("clears", 12'h1, 12'(n_clr));
        for (int i = 1; i < 8; i++) begin
            op_u.press(1'b1, 1'b0, ONE + 12);
            chk("item", 12'(i), 12'(item));
        end
        op_u.press(1'b1, 1'b0, 30);
        chk("item", 12'h6, 12'(item));
        op_u.press(1'b1, 1'b0, ONE + 12);
        chk("digit_reg", 12'ha, 12'(dreg));
        chk("digit2", 12'h1, 12'(d2));
        chk("reg_on", 12'h1, 12'(regon));
    endtask
    // Edits the address 146 into 157 and commits it
    task automatic t_set;
        op_u.press(1'b0, 1'b1, TEN + 30);
        chk("edit", 12'h1, 12'(gb));
        op_u.press(1'b1, 1'b0, 10);
        chk("digit0", 12'h7, 12'(d0));
        op_u.press(1'b0, 1'b1, 10);
        chk("edit", 12'h2, 12'(gb));
        op_u.press(1'b1, 1'b0, 10);
        chk("digit1", 12'h5, 12'(d1));
        op_u.press(1'b1, 1'b1, 15);
        repeat (ONE) @(posedge clk);
        @(negedge clk);
        chk("stores", 12'h1, 12'(n_store));
        chk("address", 12'h157, 12'(addr));
        op_u.press(1'b0, 1'b1, TEN + 30);
        chk("edit", 12'h0, 12'(gb));
    endtask
    task automatic t_knob;
        op_u.press(1'b0, 1'b1, ONE + 12);
        chk("submenu", 12'h1, 12'(sub));
        op_u.press(1'b1, 1'b0, 30);
        chk("submenu", 12'h0, 12'(sub));
        @(posedge clk);
        knob <= 5'h04;
        @(posedge clk);
        knob <= 5'h00;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("item", 12'h2, 12'(item));
        chk("knob_led", 12'h1, 12'(led[2]));
    endtask
    initial begin
        i_rst = 1'b1;
        wr = 1'b0;
        pw = 1'b0;
        prm = 1'b0;
        knob = 5'h00;
        kval = 12'h000;
        ival = 12'h123;
        repeat (16) @(posedge clk);
        i_rst <= 1'b0;
        t_power;
        t_remote;
        t_nav;
        t_set;
        t_knob;
        wrap_up;
    end
    // Whole run needs about 2000 cycles
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        wrap_up;
    end
endmodule
`default_nettype wire
